/* ddr_cmd_issuer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_map.svh"
module ddr_cmd_issuer
  import ddr_cmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire cmd_t req_cmd,
  input wire logic [`BA_W-1:0] req_bank,
  input wire logic req_ap,
  output logic req_done,
  output logic req_err,
  ddr_cmd_if.ctrl mem
);
  // ****************************************
  // Memory clock divider
  // ****************************************
  logic [2:0] div_reg;
  logic mclk_reg;
  logic div_end;
  logic tick;

  assign div_end = div_reg == 3'(`MCLK_HALF - 1);
  // Pins change on the falling edge, half a period before the device samples
  assign tick = div_end & mclk_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 3'h0;
      mclk_reg <= 1'b0;
    end else if (clk_en) begin
      div_reg <= div_end ? 3'h0 : div_reg + 3'h1;
      if (div_end) begin
        mclk_reg <= ~mclk_reg;
      end
    end
  end

  // ****************************************
  // Timing windows shared by all banks
  // ****************************************
  logic [7:0] rd_wait_reg;
  logic [7:0] wr_wait_reg;
  logic [7:0] dev_wait_reg;
  logic [7:0] burst_reg;
  logic cke_reg;
  bank_state_t bst_reg [`NBANK];
  bank_state_t eff [`NBANK];
  bank_state_t tgt;
  logic [`NBANK-1:0] idle_vec;
  logic [`NBANK-1:0] pre_vec;
  logic all_idle;
  logic all_pre;
  logic rd_ok;
  logic wr_ok;
  logic dev_ok;
  logic burst_ok;
  logic legal;
  logic hopeless;
  logic go;
  logic is_rd;
  logic is_wr;
  logic rw_go;

  assign tgt = eff[req_bank];
  assign all_idle = idle_vec == {`NBANK{1'b1}};
  assign all_pre = pre_vec == {`NBANK{1'b1}};
  assign rd_ok = rd_wait_reg <= 8'h01;
  assign wr_ok = wr_wait_reg <= 8'h01;
  assign dev_ok = dev_wait_reg <= 8'h01;
  assign burst_ok = burst_reg <= 8'h01;
  assign is_rd = req_cmd == C_RD;
  assign is_wr = req_cmd == C_WR;

  // Only combinations the state tables allow ever leave this block
  assign legal = cke_reg && dev_ok && (
    req_cmd == C_NOP
    || req_cmd == C_ACT && tgt == B_IDLE
    || req_cmd == C_PRE && pre_ok(tgt)
    || is_rd && tgt == B_OPEN && rd_ok
    || is_wr && tgt == B_OPEN && wr_ok
    || req_cmd == C_PREA && all_pre
    || (req_cmd == C_REF || req_cmd == C_LM)
       && all_idle && burst_ok);
  // Waiting would never help: the bank sits in a stable wrong state
  assign hopeless = req_cmd == C_ACT && tgt == B_OPEN
    || (is_rd || is_wr) && tgt == B_IDLE;
  assign go = tick && req_valid && legal;
  assign rw_go = go && (is_rd || is_wr);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_wait_reg <= 8'h00;
      wr_wait_reg <= 8'h00;
      dev_wait_reg <= 8'h00;
      burst_reg <= 8'h00;
    end else if (clk_en && tick) begin
      if (rw_go && is_rd) begin
        rd_wait_reg <= hold(rd_wait_reg, 8'(`RD_RD_CK));
        wr_wait_reg <= hold(wr_wait_reg, 8'(`RD_WR_CK));
        burst_reg <= hold(burst_reg, 8'(`RD_BUSY_CK));
      end else if (rw_go) begin
        rd_wait_reg <= hold(rd_wait_reg, 8'(`WR_RD_CK));
        wr_wait_reg <= hold(wr_wait_reg, 8'(`WR_WR_CK));
        burst_reg <= hold(burst_reg, 8'(`WR_BUSY_CK));
      end else begin
        rd_wait_reg <= hold(rd_wait_reg, 8'h00);
        wr_wait_reg <= hold(wr_wait_reg, 8'h00);
        burst_reg <= hold(burst_reg, 8'h00);
      end
      if (go && req_cmd == C_REF) begin
        dev_wait_reg <= 8'(`RFC_CK);
      end else if (go && req_cmd == C_LM) begin
        dev_wait_reg <= 8'(`T_MRD_CK);
      end else if (go && req_cmd == C_PREA) begin
        dev_wait_reg <= 8'(`RP_CK);
      end else begin
        dev_wait_reg <= hold(dev_wait_reg, 8'h00);
      end
    end
  end

  // ****************************************
  // Mirror of each bank's state
  // ****************************************
  for (genvar b = 0; b < `NBANK; b++) begin : g_bank
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    bank_state_t st_next;
    logic hit;

    assign eff[b] = bank_eff(bst_reg[b], cnt_reg);
    assign idle_vec[b] = eff[b] == B_IDLE;
    assign pre_vec[b] = pre_ok(eff[b]);
    assign hit = go && req_bank == `BA_W'(b);

    always_comb begin
      st_next = eff[b];
      cnt_next = hold(cnt_reg, 8'h00);
      if (go && req_cmd == C_PREA) begin
        st_next = B_PRE;
        cnt_next = 8'(`RP_CK);
      end else if (hit) begin
        case (req_cmd)
          C_ACT: begin
            st_next = B_ACT;
            cnt_next = 8'(`RCD_CK);
          end
          C_PRE: begin
            st_next = B_PRE;
            cnt_next = 8'(`RP_CK);
          end
          C_RD: begin
            if (req_ap) begin
              st_next = B_RDAP;
              cnt_next = 8'(`RDAP_CK);
            end
          end
          C_WR: begin
            if (req_ap) begin
              st_next = B_WRAP;
              cnt_next = 8'(`WRAP_CK);
            end
          end
          default: st_next = eff[b];
        endcase
      end
    end

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        bst_reg[b] <= B_IDLE;
        cnt_reg <= 8'h00;
      end else if (clk_en && tick) begin
        bst_reg[b] <= st_next;
        cnt_reg <= cnt_next;
      end
    end
  end

  // ****************************************
  // Command pins and request answers
  // ****************************************
  logic cs_b_reg;
  logic [2:0] rcw_reg;
  logic ap_reg;
  logic [`BA_W-1:0] ba_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cke_reg <= 1'b0;
      cs_b_reg <= 1'b1;
      rcw_reg <= 3'h7;
      ap_reg <= 1'b0;
      ba_reg <= `BA_W'(0);
      req_done <= 1'b0;
      req_err <= 1'b0;
    end else if (clk_en) begin
      req_done <= go;
      req_err <= tick && req_valid && !legal && hopeless;
      if (tick) begin
        cke_reg <= 1'b1;
        // Deselect between commands keeps the device running undisturbed
        cs_b_reg <= !go;
        rcw_reg <= go ? cmd_pins(req_cmd) : 3'h7;
        ap_reg <= go && (req_cmd == C_PREA
                         || (is_rd || is_wr) && req_ap);
        ba_reg <= req_bank;
      end
    end
  end

  assign mem.mem_clk = mclk_reg;
  assign mem.cke = cke_reg;
  assign mem.cs_b = cs_b_reg;
  assign mem.ras_b = rcw_reg[2];
  assign mem.cas_b = rcw_reg[1];
  assign mem.we_b = rcw_reg[0];
  assign mem.ap_sel = ap_reg;
  assign mem.ba = ba_reg;
endmodule
`default_nettype wire

/* ddr_cmd_map.svh */
`ifndef DDR_CMD_MAP_SVH
`define DDR_CMD_MAP_SVH
// How it works
// - Commands decoded from select, strobes, enable at rise.
// - Auto precharge pin picks close or keep row.
// - Tables apply only with enable high twice.
// - No command to a bank in transient state.
// - Precharge makes bank idle after precharge period.
// - Activate opens row after activate delay.
// - Read auto precharge busy until precharge ends.
// - Write auto precharge busy until precharge ends.
// - Refresh needs only no-ops until cycle ends.
// - Mode load needs only no-ops until delay.
// - Precharge all needs no-ops until period ends.
// - Refresh and mode load need all idle.
// - Each precharged bank must permit precharging.
// - Other banks take commands their state allows.
// - Write after read waits for burst end.
// - Read auto precharge starts at earliest precharge.
// - Write auto precharge starts after write recovery.
// - Other banks usable during auto precharge, no contention.
// - Cross-bank delays after auto precharge commands.
// - Write-to-read delay at least two clocks.
// - Deselect runs nothing new, work continues.
// - Controller never makes an illegal combination.
`define NBANK 4
`define BA_W 2
`define CLK_PS 25000
`define MCLK_HALF 4
`define MCLK_PS (`CLK_PS * 2 * `MCLK_HALF)
`define T_RP_PS 15000
`define T_RCD_PS 15000
`define T_RFC_PS 105000
`define T_WR_PS 15000
`define T_WTR_PS 7500
`define T_MRD_CK 2
`define READ_LATENCY 3
`define BURST_LENGTH 4
`define CK(ps) (((ps) + `MCLK_PS - 1) / `MCLK_PS)
`define RP_CK `CK(`T_RP_PS)
`define RCD_CK `CK(`T_RCD_PS)
`define RFC_CK `CK(`T_RFC_PS)
`define WR_CK `CK(`T_WR_PS)
`define WTR_CK ((`CK(`T_WTR_PS) > 2) ? `CK(`T_WTR_PS) : 2)
`define HALF_BL (`BURST_LENGTH / 2)
`define RDAP_CK (`HALF_BL + `RP_CK)
`define WRAP_CK ((`READ_LATENCY - 1) + `HALF_BL + `WR_CK + `RP_CK)
`define RD_RD_CK `HALF_BL
`define RD_WR_CK (`HALF_BL + 2)
`define WR_RD_CK ((`READ_LATENCY - 1) + `HALF_BL + `WTR_CK)
`define WR_WR_CK `HALF_BL
`define RD_BUSY_CK (`READ_LATENCY + `HALF_BL)
`define WR_BUSY_CK ((`READ_LATENCY - 1) + `HALF_BL)
`endif

/* ddr_cmd_pkg.sv */
`default_nettype none
`include "ddr_cmd_map.svh"
package ddr_cmd_pkg;
  typedef enum logic [5:0] {
    B_IDLE = 6'h01,
    B_PRE = 6'h02,
    B_ACT = 6'h04,
    B_OPEN = 6'h08,
    B_RDAP = 6'h10,
    B_WRAP = 6'h20
  } bank_state_t;
  typedef enum logic [2:0] {
    D_NORM = 3'h1,
    D_REF = 3'h2,
    D_LMR = 3'h4
  } dev_mode_t;
  typedef enum logic [2:0] {
    C_NOP = 3'h0,
    C_ACT = 3'h1,
    C_RD = 3'h2,
    C_WR = 3'h3,
    C_PRE = 3'h4,
    C_PREA = 3'h5,
    C_REF = 3'h6,
    C_LM = 3'h7
  } cmd_t;

  // State a bank holds at this edge once a running delay expires
  function automatic bank_state_t bank_eff(input bank_state_t s,
                                           input logic [7:0] c);
    bank_state_t r;
    r = s;
    if (c == 8'h01) begin
      if (s == B_ACT) begin
        r = B_OPEN;
      end else if (s != B_OPEN) begin
        r = B_IDLE;
      end
    end
    return r;
  endfunction

  function automatic logic pre_ok(input bank_state_t s);
    return (s == B_IDLE) || (s == B_OPEN) || (s == B_PRE);
  endfunction

  // Decrement, but never shorten a wait already running
  function automatic logic [7:0] hold(input logic [7:0] cur,
                                      input logic [7:0] load);
    logic [7:0] d;
    d = (cur != 8'h00) ? cur - 8'h01 : 8'h00;
    return (load > d) ? load : d;
  endfunction

  function automatic logic [2:0] cmd_pins(input cmd_t c);
    logic [2:0] p;
    p = 3'h7;
    case (c)
      C_ACT: p = 3'h3;
      C_RD: p = 3'h5;
      C_WR: p = 3'h4;
      C_PRE, C_PREA: p = 3'h2;
      C_REF: p = 3'h1;
      C_LM: p = 3'h0;
      default: p = 3'h7;
    endcase
    return p;
  endfunction

  function automatic cmd_t cmd_decode(input logic cs_b,
                                      input logic [2:0] rcw,
                                      input logic ap);
    cmd_t c;
    c = C_NOP;
    if (!cs_b) begin
      case (rcw)
        3'h3: c = C_ACT;
        3'h5: c = C_RD;
        3'h4: c = C_WR;
        3'h2: c = ap ? C_PREA : C_PRE;
        3'h1: c = C_REF;
        3'h0: c = C_LM;
        default: c = C_NOP;
      endcase
    end
    return c;
  endfunction
endpackage
`default_nettype wire

/* ddr_cmd_if.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_map.svh"
interface ddr_cmd_if;
  logic mem_clk;
  logic cke;
  logic cs_b;
  logic ras_b;
  logic cas_b;
  logic we_b;
  logic ap_sel;
  logic [`BA_W-1:0] ba;
  modport ctrl (output mem_clk, cke, cs_b, ras_b, cas_b, we_b, ap_sel, ba);
  modport device (input mem_clk, cke, cs_b, ras_b, cas_b, we_b, ap_sel, ba);
endinterface
`default_nettype wire

/* ddr_bank_tracker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_map.svh"
module ddr_bank_tracker
  import ddr_cmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  ddr_cmd_if.device mem,
  output var bank_state_t bank_state [`NBANK],
  output logic all_idle,
  output logic illegal_cmd
);
  // ****************************************
  // Pin synchroniser and memory clock edge
  // ****************************************
  logic [8:0] pin_raw;
  logic [8:0] s1_reg;
  logic [8:0] s2_reg;
  logic [8:0] s3_reg;
  logic [8:0] pin_reg;
  logic [8:0] agree;
  logic [8:0] pin_next;
  logic mclk_prev_reg;
  logic cke_prev_reg;
  logic tick;
  logic live;
  cmd_t cmd;
  logic [`BA_W-1:0] bank;

  assign pin_raw = {mem.mem_clk, mem.cke, mem.cs_b, mem.ras_b, mem.cas_b,
                    mem.we_b, mem.ba, mem.ap_sel};
  // A bit moves only once the second and third stages agree
  assign agree = ~(s2_reg ^ s3_reg);
  assign pin_next = (s2_reg & agree) | (pin_reg & ~agree);
  assign tick = pin_reg[8] & ~mclk_prev_reg;
  assign live = tick & cke_prev_reg & pin_reg[7];
  assign cmd = cmd_decode(pin_reg[6], pin_reg[5:3], pin_reg[0]);
  assign bank = pin_reg[2:1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 9'h000;
      s2_reg <= 9'h000;
      s3_reg <= 9'h000;
      pin_reg <= 9'h000;
      mclk_prev_reg <= 1'b0;
      cke_prev_reg <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
      mclk_prev_reg <= pin_reg[8];
      if (tick) begin
        cke_prev_reg <= pin_reg[7];
      end
    end
  end

  // ****************************************
  // Device-wide state
  // ****************************************
  dev_mode_t mode_reg;
  dev_mode_t mode_next;
  logic [7:0] dev_cnt_reg;
  logic [7:0] dev_cnt_next;
  logic [7:0] burst_reg;
  logic [7:0] burst_next;
  bank_state_t eff [`NBANK];
  logic [`NBANK-1:0] bad_vec;
  logic [`NBANK-1:0] idle_vec;
  logic [`NBANK-1:0] pre_vec;
  logic dev_free;
  logic dev_bad;
  logic bank_rw;

  assign dev_free = (mode_reg == D_NORM) || (dev_cnt_reg == 8'h01);
  assign bank_rw = live && eff[bank] == B_OPEN && (cmd == C_RD || cmd == C_WR);
  // Any executable command during refresh or mode load is a violation
  assign dev_bad = live && cmd != C_NOP && !dev_free
    || live && (cmd == C_REF || cmd == C_LM)
       && (idle_vec != {`NBANK{1'b1}} || burst_reg > 8'h01)
    || live && cmd == C_PREA && pre_vec != {`NBANK{1'b1}};

  always_comb begin
    mode_next = dev_free ? D_NORM : mode_reg;
    dev_cnt_next = hold(dev_cnt_reg, 8'h00);
    burst_next = hold(burst_reg, 8'h00);
    // A refused refresh or mode load leaves the device as it was
    if (live && cmd == C_REF && !dev_bad) begin
      mode_next = D_REF;
      dev_cnt_next = 8'(`RFC_CK);
    end else if (live && cmd == C_LM && !dev_bad) begin
      mode_next = D_LMR;
      dev_cnt_next = 8'(`T_MRD_CK);
    end
    if (bank_rw) begin
      burst_next = (cmd == C_RD) ? 8'(`RD_BUSY_CK) : 8'(`WR_BUSY_CK);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= D_NORM;
      dev_cnt_reg <= 8'h00;
      burst_reg <= 8'h00;
      all_idle <= 1'b1;
      illegal_cmd <= 1'b0;
    end else if (clk_en) begin
      if (tick) begin
        mode_reg <= mode_next;
        dev_cnt_reg <= dev_cnt_next;
        burst_reg <= burst_next;
      end
      all_idle <= (idle_vec == {`NBANK{1'b1}}) && (mode_reg == D_NORM);
      illegal_cmd <= dev_bad || (bad_vec != {`NBANK{1'b0}});
    end
  end

  // ****************************************
  // Per-bank state
  // ****************************************
  for (genvar b = 0; b < `NBANK; b++) begin : g_bank
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    bank_state_t st_next;
    logic hit;
    logic bad;

    assign eff[b] = bank_eff(bank_state[b], cnt_reg);
    assign idle_vec[b] = eff[b] == B_IDLE;
    assign pre_vec[b] = pre_ok(eff[b]);
    // Deselect decodes to no-op, so counters simply keep running
    assign hit = live && dev_free && bank == `BA_W'(b);
    assign bad_vec[b] = bad;

    always_comb begin
      st_next = eff[b];
      cnt_next = hold(cnt_reg, 8'h00);
      bad = 1'b0;
      if (live && dev_free && cmd == C_PREA) begin
        st_next = B_PRE;
        cnt_next = 8'(`RP_CK);
      end else if (hit) begin
        case (cmd)
          C_ACT: begin
            bad = eff[b] != B_IDLE;
            if (!bad) begin
              st_next = B_ACT;
              cnt_next = 8'(`RCD_CK);
            end
          end
          C_PRE: begin
            bad = !pre_ok(eff[b]);
            if (!bad) begin
              st_next = B_PRE;
              cnt_next = 8'(`RP_CK);
            end
          end
          C_RD, C_WR: begin
            bad = eff[b] != B_OPEN;
            if (!bad && pin_reg[0]) begin
              // Busy through the access and the precharge that follows
              st_next = (cmd == C_RD) ? B_RDAP : B_WRAP;
              cnt_next = (cmd == C_RD) ? 8'(`RDAP_CK)
                                       : 8'(`WRAP_CK);
            end
          end
          default: bad = 1'b0;
        endcase
      end
    end

    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        bank_state[b] <= B_IDLE;
        cnt_reg <= 8'h00;
      end else if (clk_en && tick) begin
        bank_state[b] <= st_next;
        cnt_reg <= cnt_next;
      end
    end
  end
endmodule
`default_nettype wire

/* ddr_cmd_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_map.svh"
module ddr_cmd_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_clk,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic ap_sel,
  input wire logic [`BA_W-1:0] ba
);
  // ********************************************
  // Commands seen at each memory clock rise
  // ********************************************
  localparam int RDAP = `RDAP_CK;
  localparam int WRAP = `WRAP_CK;
  logic mclk_d_reg;
  logic [3:0] rd_gap_reg;
  logic [3:0] wr_gap_reg;
  logic [3:0] lm_gap_reg;
  logic [3:0] ap_gap_reg;
  logic [3:0] ap_busy_reg;
  logic [`BA_W-1:0] ap_bank_reg;
  wire rise = mem_clk && !mclk_d_reg;
  wire [2:0] rcw = {ras_b, cas_b, we_b};
  wire sel = rise && !cs_b;
  wire is_rd = sel && (rcw == 3'h5);
  wire is_wr = sel && (rcw == 3'h4);
  wire is_cmd = sel && (rcw != 3'h7);
  wire bank_cmd = is_rd || is_wr || (sel && (rcw == 3'h3 || rcw == 3'h2));
  wire ap_new = (is_rd || is_wr) && ap_sel;
  // Gaps count rises since the last such command and saturate at 15
  function automatic logic [3:0] inc(input logic [3:0] g);
    return (g == 4'hf) ? g : g + 4'h1;
  endfunction
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mclk_d_reg <= 1'b0;
      rd_gap_reg <= 4'hf;
      wr_gap_reg <= 4'hf;
      lm_gap_reg <= 4'hf;
      ap_gap_reg <= 4'hf;
      ap_busy_reg <= 4'h0;
      ap_bank_reg <= '0;
    end else begin
      mclk_d_reg <= mem_clk;
      if (rise) begin
        rd_gap_reg <= is_rd ? 4'h1 : inc(rd_gap_reg);
        wr_gap_reg <= is_wr ? 4'h1 : inc(wr_gap_reg);
        lm_gap_reg <= (sel && rcw == 3'h0) ? 4'h1 : inc(lm_gap_reg);
        ap_gap_reg <= ap_new ? 4'h1 : inc(ap_gap_reg);
      end
      if (ap_new) begin
        ap_bank_reg <= ba;
        ap_busy_reg <= is_rd ? 4'(RDAP) : 4'(WRAP);
      end
    end
  end
  // ********************************************
  // Checks
  // ********************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  pins_stable_a: assert property (mem_clk && $past(mem_clk) |->
    $stable({cs_b, rcw, ap_sel, ba})) else $error("pins moved at high clock");
  mclk_shape_a: assert property ($rose(mem_clk) |->
    mem_clk [*4] ##1 !mem_clk [*4]) else $error("memory clock shape wrong");
  cke_kept_a: assert property (cke |=> cke)
    else $error("clock enable dropped");
  cmd_needs_cke_a: assert property (is_cmd |->
    cke && $past(cke, 8)) else $error("command without enable on two edges");
  rd_to_wr_a: assert property (is_wr |-> rd_gap_reg >= `RD_WR_CK)
    else $error("write too soon after read");
  wr_to_rd_a: assert property (is_rd |-> wr_gap_reg >= `WR_RD_CK)
    else $error("read too soon after write");
  rd_spacing_a: assert property (is_rd |->
    rd_gap_reg >= `RD_RD_CK) else $error("reads too close");
  wr_spacing_a: assert property (is_wr |->
    wr_gap_reg >= `WR_WR_CK) else $error("writes too close");
  mode_wait_a: assert property (is_cmd |->
    lm_gap_reg >= `T_MRD_CK) else $error("command during mode load wait");
  ap_bank_busy_a: assert property (bank_cmd && ba == ap_bank_reg
    |-> ap_gap_reg >= ap_busy_reg)
    else $error("command to auto precharge bank");
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_map.svh"
module testbench import ddr_cmd_pkg::*;;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  cmd_t req_cmd = C_NOP;
  logic [1:0] req_bank = 2'h0;
  logic req_ap = 1'b0;
  logic req_done, req_err, idle_a, idle_b, ill_a, ill_b;
  bank_state_t st_a [`NBANK];
  bank_state_t st_b [`NBANK];
  int err_total = 0;
  int checks = 0;
  int ill_a_n = 0;
  int ill_b_n = 0;
  int done_cyc = 0;
  int cyc = 0;
  ddr_cmd_if link();
  ddr_cmd_if link_b();
  ddr_cmd_issuer u_ddr_cmd_issuer (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_ap(req_ap), .req_done(req_done),
    .req_err(req_err), .mem(link));
  ddr_bank_tracker u_ddr_bank_tracker (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .mem(link), .bank_state(st_a), .all_idle(idle_a),
    .illegal_cmd(ill_a));
  // Second device end faces the bench, which breaks the rules on purpose
  ddr_bank_tracker u_ddr_bank_tracker_b (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .mem(link_b), .bank_state(st_b), .all_idle(idle_b),
    .illegal_cmd(ill_b));
  ddr_cmd_checker u_ddr_cmd_checker (.clock(clock), .rst_b(rst_b),
    .mem_clk(link.mem_clk), .cke(link.cke), .cs_b(link.cs_b),
    .ras_b(link.ras_b), .cas_b(link.cas_b), .we_b(link.we_b),
    .ap_sel(link.ap_sel), .ba(link.ba));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ill_a_n <= ill_a_n + ((ill_a === 1'b1) ? 1 : 0);
    ill_b_n <= ill_b_n + ((ill_b === 1'b1) ? 1 : 0);
  end
  // Free running link clock, phase unrelated to the system clock
  initial begin
    link_b.mem_clk = 1'b0;
    #33;
    forever #100 link_b.mem_clk = ~link_b.mem_clk;
  end
  // ********************************************
  // Compare and drive tasks
  // ********************************************
  task automatic chk_state(input string n, input bank_state_t e,
                           input bank_state_t g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask
  task automatic chk_min(input string n, input int e, input int g);
    checks++;
    if (g < e) begin
      err_total++;
      $display("unexpected %s: expected at least %0d, seen %0d", n, e, g);
    end
  endtask
  task automatic chk_int(input string n, input int e, input int g);
    checks++;
    if (g != e) begin
      err_total++;
      $display("unexpected %s: expected %0d, seen %0d", n, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic issue(input cmd_t c, input logic [1:0] b, input logic ap,
                       input logic e);
    int n;
    n = 0;
    @(negedge clock);
    {req_valid, req_cmd, req_bank, req_ap} = {1'b1, c, b, ap};
    while (req_done !== 1'b1 && req_err !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk_bit("request answered", 1'b1, req_done | req_err);
    chk_bit("request refused", e, req_err);
    done_cyc = cyc;
    req_valid = 1'b0;
  endtask
  // Bits: enable, select, three strobes, auto precharge, bank
  task automatic drv(input logic [7:0] v);
    @(negedge link_b.mem_clk);
    @(negedge clock);
    {link_b.cke, link_b.cs_b, link_b.ras_b, link_b.cas_b, link_b.we_b,
     link_b.ap_sel, link_b.ba} = v;
  endtask
  // ********************************************
  // Scenarios
  // ********************************************
  task automatic reset_values();
    for (int i = 0; i < `NBANK; i++) begin
      chk_state("reset bank", B_IDLE, st_a[i]);
    end
    chk_bit("reset all idle", 1'b1, idle_a);
    chk_bit("reset select", 1'b1, link.cs_b);
  endtask
  task automatic row_read();
    issue(C_ACT, 2'h0, 1'b0, 1'b0);
    ticks(10);
    chk_state("bank 0 activating", B_ACT, st_a[0]);
    ticks(10);
    chk_state("bank 0 open", B_OPEN, st_a[0]);
    issue(C_RD, 2'h0, 1'b1, 1'b0);
    ticks(8 * `RDAP_CK - 4);
    chk_state("bank 0 read ap", B_RDAP, st_a[0]);
    ticks(16);
    chk_state("bank 0 after read ap", B_IDLE, st_a[0]);
  endtask
  task automatic row_write();
    int t0;
    issue(C_ACT, 2'h1, 1'b0, 1'b0);
    ticks(20);
    issue(C_WR, 2'h1, 1'b1, 1'b0);
    t0 = done_cyc;
    issue(C_ACT, 2'h2, 1'b0, 1'b0);
    while (cyc < t0 + 8 * `WRAP_CK - 4) @(negedge clock);
    chk_state("bank 1 write ap", B_WRAP, st_a[1]);
    ticks(16);
    chk_state("bank 1 after write ap", B_IDLE, st_a[1]);
    chk_state("bank 2 beside auto precharge", B_OPEN, st_a[2]);
    issue(C_PRE, 2'h2, 1'b0, 1'b0);
    ticks(10);
    chk_state("bank 2 precharging", B_PRE, st_a[2]);
    ticks(10);
    chk_state("bank 2 precharged", B_IDLE, st_a[2]);
  endtask
  task automatic device_wide();
    issue(C_REF, 2'h0, 1'b0, 1'b0);
    ticks(10);
    chk_bit("idle in refresh", 1'b0, idle_a);
    ticks(14);
    chk_bit("idle after refresh", 1'b1, idle_a);
    issue(C_LM, 2'h0, 1'b0, 1'b0);
    ticks(18);
    chk_bit("idle in mode load", 1'b0, idle_a);
    ticks(12);
    chk_bit("idle after mode load", 1'b1, idle_a);
    issue(C_ACT, 2'h0, 1'b0, 1'b0);
    issue(C_ACT, 2'h3, 1'b0, 1'b0);
    ticks(20);
    issue(C_PREA, 2'h0, 1'b0, 1'b0);
    ticks(10);
    chk_state("bank 0 in precharge all", B_PRE, st_a[0]);
    chk_state("bank 3 in precharge all", B_PRE, st_a[3]);
    ticks(10);
    chk_state("bank 3 after precharge all", B_IDLE, st_a[3]);
  endtask
  task automatic spacing();
    int t0;
    issue(C_ACT, 2'h0, 1'b0, 1'b0);
    issue(C_ACT, 2'h1, 1'b0, 1'b0);
    issue(C_RD, 2'h0, 1'b0, 1'b0);
    t0 = done_cyc;
    issue(C_WR, 2'h1, 1'b0, 1'b0);
    chk_min("read to write", 8 * `RD_WR_CK, done_cyc - t0);
    t0 = done_cyc;
    issue(C_RD, 2'h0, 1'b0, 1'b0);
    chk_min("write to read", 8 * `WR_RD_CK, done_cyc - t0);
    t0 = done_cyc;
    issue(C_RD, 2'h1, 1'b0, 1'b0);
    chk_min("read to read", 8 * `RD_RD_CK, done_cyc - t0);
    issue(C_PREA, 2'h0, 1'b0, 1'b0);
    issue(C_RD, 2'h2, 1'b0, 1'b1);
    ticks(20);
  endtask
  task automatic device_faults();
    int i0;
    drv(8'hf8);
    drv(8'hdc);
    drv(8'h19);
    drv(8'hb8);
    ticks(12);
    chk_state("bank 0 deselected", B_IDLE, st_b[0]);
    chk_bit("idle after deselect", 1'b1, idle_b);
    chk_state("bank 1 enable low", B_IDLE, st_b[1]);
    i0 = ill_b_n;
    drv(8'haa);
    drv(8'hf8);
    ticks(12);
    chk_int("illegal read count", i0 + 1, ill_b_n);
    chk_state("bank 2 refused read", B_IDLE, st_b[2]);
    drv(8'h9b);
    drv(8'ha7);
    drv(8'h9b);
    drv(8'h98);
    drv(8'hf8);
    ticks(14);
    chk_int("illegal busy count", i0 + 2, ill_b_n);
    chk_state("bank 3 busy", B_WRAP, st_b[3]);
    chk_state("bank 0 beside busy", B_OPEN, st_b[0]);
    chk_bit("idle beside busy", 1'b0, idle_b);
    drv(8'h88);
    drv(8'hf8);
    ticks(12);
    chk_int("illegal refresh count", i0 + 3, ill_b_n);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {link_b.cke, link_b.cs_b, link_b.ras_b, link_b.cas_b, link_b.we_b,
     link_b.ap_sel, link_b.ba} = 8'h78;
    repeat (12) @(posedge clock);
    @(negedge clock);
    reset_values();
    rst_b = 1'b1;
    row_read();
    row_write();
    device_wide();
    spacing();
    device_faults();
    chk_int("illegal count main pair", 0, ill_a_n);
    give_verdict();
  end
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
